// ==== design/fic_arb_if.sv ====
// Request and winner signals between controller and arbiter
`timescale 1ns/1ps
interface fic_arb_if;
    logic [12:0] pending;
    fic_pkg::fic_lvl_t level [13];
    logic found;
    fic_pkg::fic_idx_t winIdx;
    fic_pkg::fic_lvl_t winLvl;

    modport ctrl (output pending, output level, input found,
        input winIdx, input winLvl);
    modport arb (input pending, input level, output found,
        output winIdx, output winLvl);
endinterface

// ==== design/fic_arbiter.sv ====
// Picks the highest level pending source, lowest order on a tie
`timescale 1ns/1ps
module fic_arbiter (
    input wire logic ref_clk,
    input wire logic reset,
    fic_arb_if.arb arb
);
    logic [12:0] tieMask;

    always_comb
    begin
        arb.found = 1'b0;
        arb.winIdx = 4'h0;
        arb.winLvl = 3'h0;
        for (int i = 0; i < fic_pkg::NumSrc; i++)
        begin
            // Strictly higher only, so the earlier source keeps a tie
            if (arb.pending[i] && (!arb.found || arb.level[i] > arb.winLvl))
            begin
                arb.found = 1'b1;
                arb.winIdx = 4'(i);
                arb.winLvl = arb.level[i];
            end
        end
    end

    // Earlier pending sources at the winning level
    always_comb
    begin
        for (int i = 0; i < fic_pkg::NumSrc; i++)
            tieMask[i] = arb.pending[i] && (arb.level[i] == arb.winLvl)
                && (4'(i) < arb.winIdx);
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_TIE_ORDER: assert property (arb.found |-> tieMask == 13'h0)
        else $error("tie not resolved by natural order");
    AST_PF_TOP: assert property (arb.pending[0] |-> arb.winIdx == 4'h0
        && arb.winLvl == 3'h4)
        else $error("power-fail not ranked on top");
endmodule // fic_arbiter

// ==== design/fic_irq_ctrl.sv ====
// Five-level interrupt controller: flags, enables, levels, vectoring
`timescale 1ns/1ps
module fic_irq_ctrl (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ext0PinN,
    input wire logic ext1PinN,
    input wire logic pfDetect,
    input wire logic tmr0Ovf,
    input wire logic tmr1Ovf,
    input wire logic tmr2Ovf,
    input wire logic tmr2Ext,
    input wire logic ser0Rx,
    input wire logic ser0Tx,
    input wire logic ser1Rx,
    input wire logic ser1Tx,
    input wire logic [3:0] extHiEvt,
    input wire logic wdTimeout,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic vecAck,
    input wire logic retiDone,
    output logic intReq,
    output logic [7:0] vectorAddr,
    output fic_pkg::fic_lvl_t intLevel,
    output logic irqOut
);
    logic [7:0] tmrCtl_q, tmrCtl_d, extFlags_q, extFlags_d;
    logic [7:0] ser0Ctl_q, ser0Ctl_d, ser1Ctl_q, ser1Ctl_d;
    logic [7:0] tmr2Ctl_q, tmr2Ctl_d, wdCtl_q, wdCtl_d;
    logic [7:0] intEn_q, prioLow_q, prioHigh_q;
    logic [7:0] extEn_q, extPrioLow_q, extPrioHigh_q;
    logic [7:0] evtStatus_q, evtStatus_d, evtMask_q, evtSet;
    logic [7:0] rdMux_d, regRdData_q, vectorAddr_q;
    logic ext0Prev_q, ext1Prev_q, ext0Fall, ext1Fall;
    logic edge0, edge1, globalEn, taken, canTake, active;
    logic intReq_q;
    fic_pkg::fic_idx_t winIdx_q;
    fic_pkg::fic_lvl_t winLvl_q, curLvl;
    logic [4:0] inService;

    fic_arb_if arb ();

    function automatic logic [7:0] bitAt(input logic en, input int pos);
        logic [7:0] m;
        m = 8'h00;
        m[pos[2:0]] = en;
        return m;
    endfunction

    // Hardware set wins over any clear in the same cycle
    function automatic logic [7:0] flagNext(input logic [7:0] q,
        input logic hit, input logic [7:0] wd, input logic [7:0] clr,
        input logic [7:0] set);
        return (((hit ? wd : q) & ~clr) | set);
    endfunction

    function automatic logic wrHit(input logic [7:0] a);
        return regWr && (regAddr == a);
    endfunction

    function automatic logic ackOf(input fic_pkg::fic_idx_t s);
        return taken && (winIdx_q == s);
    endfunction

    assign edge0 = tmrCtl_q[fic_pkg::TcEdge0];
    assign edge1 = tmrCtl_q[fic_pkg::TcEdge1];
    assign globalEn = intEn_q[fic_pkg::IeGlobal];
    assign ext0Fall = ext0Prev_q & ~ext0PinN;
    assign ext1Fall = ext1Prev_q & ~ext1PinN;
    assign taken = vecAck && intReq_q;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ext0Prev_q <= 1'b1;
            ext1Prev_q <= 1'b1;
        end
        else
        begin
            ext0Prev_q <= ext0PinN;
            ext1Prev_q <= ext1PinN;
        end
    end

    // Timer control: external and timer 0/1 flags
    always_comb
    begin
        tmrCtl_d = flagNext(tmrCtl_q, wrHit(fic_pkg::RegTmrCtl), regWrData,
            bitAt(ackOf(fic_pkg::SrcExt0) && edge0, fic_pkg::TcFlag0)
            | bitAt(ackOf(fic_pkg::SrcExt1) && edge1, fic_pkg::TcFlag1)
            | bitAt(ackOf(fic_pkg::SrcTmr0), fic_pkg::TcTf0)
            | bitAt(ackOf(fic_pkg::SrcTmr1), fic_pkg::TcTf1),
            bitAt(ext0Fall && edge0, fic_pkg::TcFlag0)
            | bitAt(ext1Fall && edge1, fic_pkg::TcFlag1)
            | bitAt(tmr0Ovf, fic_pkg::TcTf0)
            | bitAt(tmr1Ovf, fic_pkg::TcTf1));
        if (!edge0)
            tmrCtl_d[fic_pkg::TcFlag0] = ~ext0PinN;
        if (!edge1)
            tmrCtl_d[fic_pkg::TcFlag1] = ~ext1PinN;
    end

    // Flags below are cleared only by software writes
    always_comb
    begin
        extFlags_d = flagNext(extFlags_q, wrHit(fic_pkg::RegExtFlags),
            regWrData, 8'h00, {4'h0, extHiEvt} << fic_pkg::ExfExt2);
        ser0Ctl_d = flagNext(ser0Ctl_q, wrHit(fic_pkg::RegSer0), regWrData,
            8'h00, bitAt(ser0Rx, fic_pkg::SerRx)
            | bitAt(ser0Tx, fic_pkg::SerTx));
        ser1Ctl_d = flagNext(ser1Ctl_q, wrHit(fic_pkg::RegSer1), regWrData,
            8'h00, bitAt(ser1Rx, fic_pkg::SerRx)
            | bitAt(ser1Tx, fic_pkg::SerTx));
        tmr2Ctl_d = flagNext(tmr2Ctl_q, wrHit(fic_pkg::RegTmr2Ctl),
            regWrData, 8'h00, bitAt(tmr2Ovf, fic_pkg::T2Tf)
            | bitAt(tmr2Ext, fic_pkg::T2Exf));
        wdCtl_d = flagNext(wdCtl_q, wrHit(fic_pkg::RegWdPwr), regWrData,
            8'h00, bitAt(pfDetect, fic_pkg::WdPfi)
            | bitAt(wdTimeout, fic_pkg::WdWdif));
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            tmrCtl_q <= fic_pkg::RstVal;
            extFlags_q <= fic_pkg::RstVal;
            ser0Ctl_q <= fic_pkg::RstVal;
            ser1Ctl_q <= fic_pkg::RstVal;
            tmr2Ctl_q <= fic_pkg::RstVal;
            wdCtl_q <= fic_pkg::RstVal;
        end
        else
        begin
            tmrCtl_q <= tmrCtl_d;
            extFlags_q <= extFlags_d;
            ser0Ctl_q <= ser0Ctl_d;
            ser1Ctl_q <= ser1Ctl_d;
            tmr2Ctl_q <= tmr2Ctl_d;
            wdCtl_q <= wdCtl_d;
        end
    end

    // Enable and level registers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            intEn_q <= fic_pkg::RstVal;
            prioLow_q <= fic_pkg::RstVal;
            prioHigh_q <= fic_pkg::RstVal;
            extEn_q <= fic_pkg::RstVal;
            extPrioLow_q <= fic_pkg::RstVal;
            extPrioHigh_q <= fic_pkg::RstVal;
            evtMask_q <= fic_pkg::RstVal;
        end
        else
        begin
            if (wrHit(fic_pkg::RegIntEn))
                intEn_q <= regWrData;
            if (wrHit(fic_pkg::RegPrioLow))
                prioLow_q <= regWrData;
            if (wrHit(fic_pkg::RegPrioHigh))
                prioHigh_q <= regWrData;
            if (wrHit(fic_pkg::RegExtEn))
                extEn_q <= regWrData;
            if (wrHit(fic_pkg::RegExtPrioLow))
                extPrioLow_q <= regWrData;
            if (wrHit(fic_pkg::RegExtPrioHigh))
                extPrioHigh_q <= regWrData;
            if (wrHit(fic_pkg::RegEvtMask))
                evtMask_q <= regWrData;
        end
    end

    // Gated requests and their levels, in natural order
    always_comb
    begin
        arb.pending[0] = wdCtl_q[fic_pkg::WdPfi]
            && wdCtl_q[fic_pkg::WdEpfi];
        arb.pending[1] = tmrCtl_q[fic_pkg::TcFlag0] && intEn_q[0];
        arb.pending[2] = tmrCtl_q[fic_pkg::TcTf0] && intEn_q[1];
        arb.pending[3] = tmrCtl_q[fic_pkg::TcFlag1] && intEn_q[2];
        arb.pending[4] = tmrCtl_q[fic_pkg::TcTf1] && intEn_q[3];
        arb.pending[5] = (ser0Ctl_q[fic_pkg::SerRx]
            || ser0Ctl_q[fic_pkg::SerTx]) && intEn_q[4];
        arb.pending[6] = (tmr2Ctl_q[fic_pkg::T2Tf]
            || tmr2Ctl_q[fic_pkg::T2Exf]) && intEn_q[5];
        arb.pending[7] = (ser1Ctl_q[fic_pkg::SerRx]
            || ser1Ctl_q[fic_pkg::SerTx]) && intEn_q[6];
        for (int k = 0; k < 4; k++)
            arb.pending[8 + k] = extFlags_q[fic_pkg::ExfExt2 + k]
                && extEn_q[k];
        arb.pending[12] = wdCtl_q[fic_pkg::WdWdif]
            && extEn_q[fic_pkg::EieWd];
        arb.pending[12:1] = arb.pending[12:1] & {12{globalEn}};
        arb.level[0] = fic_pkg::LvlPf;
        for (int i = 1; i < 8; i++)
            arb.level[i] = {1'b0, prioHigh_q[i - 1],
                prioLow_q[i - 1]};
        for (int i = 8; i < 13; i++)
            arb.level[i] = {1'b0, extPrioHigh_q[i - 8],
                extPrioLow_q[i - 8]};
    end

    fic_arbiter u_arb (
        .ref_clk(ref_clk),
        .reset(reset),
        .arb(arb)
    );

    fic_level_stack u_stack (
        .ref_clk(ref_clk),
        .reset(reset),
        .push(taken),
        .pushLvl(winLvl_q),
        .pop(retiDone),
        .inService(inService),
        .curLvl(curLvl),
        .active(active)
    );

    assign canTake = arb.found && (!active || arb.winLvl > curLvl);

    // Request to the core; drops for one cycle after each vector taken
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            intReq_q <= 1'b0;
            winIdx_q <= 4'h0;
            winLvl_q <= 3'h0;
            vectorAddr_q <= 8'h00;
        end
        else
        begin
            intReq_q <= canTake && !taken;
            winIdx_q <= arb.winIdx;
            winLvl_q <= arb.winLvl;
            vectorAddr_q <= fic_pkg::vecOf(arb.winIdx);
        end
    end

    // Sticky events, cleared by reading the status register
    always_comb
    begin
        evtSet = bitAt(taken, fic_pkg::EvTake)
            | bitAt(taken && active, fic_pkg::EvNest)
            | bitAt(retiDone && active, fic_pkg::EvRet)
            | bitAt(retiDone && !active, fic_pkg::EvRetErr);
        evtStatus_d = evtStatus_q;
        if (regRd && regAddr == fic_pkg::RegEvtStatus)
            evtStatus_d = 8'h00;
        evtStatus_d = evtStatus_d | evtSet;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            evtStatus_q <= fic_pkg::RstVal;
        else
            evtStatus_q <= evtStatus_d;
    end

    always_comb
    begin
        case (regAddr)
            fic_pkg::RegTmrCtl: rdMux_d = tmrCtl_q;
            fic_pkg::RegExtFlags: rdMux_d = extFlags_q;
            fic_pkg::RegSer0: rdMux_d = ser0Ctl_q;
            fic_pkg::RegSer1: rdMux_d = ser1Ctl_q;
            fic_pkg::RegIntEn: rdMux_d = intEn_q;
            fic_pkg::RegPrioLow: rdMux_d = prioLow_q;
            fic_pkg::RegPrioHigh: rdMux_d = prioHigh_q;
            fic_pkg::RegTmr2Ctl: rdMux_d = tmr2Ctl_q;
            fic_pkg::RegWdPwr: rdMux_d = wdCtl_q;
            fic_pkg::RegExtEn: rdMux_d = extEn_q;
            fic_pkg::RegExtPrioLow: rdMux_d = extPrioLow_q;
            fic_pkg::RegExtPrioHigh: rdMux_d = extPrioHigh_q;
            fic_pkg::RegEvtStatus: rdMux_d = evtStatus_q;
            fic_pkg::RegEvtMask: rdMux_d = evtMask_q;
            fic_pkg::RegInService: rdMux_d = {3'h0, inService};
            default: rdMux_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            regRdData_q <= 8'h00;
        else
            regRdData_q <= regRd ? rdMux_d : 8'h00;
    end

    assign regRdData = regRdData_q;
    assign intReq = intReq_q;
    assign vectorAddr = vectorAddr_q;
    assign intLevel = winLvl_q;
    assign irqOut = |(evtStatus_q & evtMask_q);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_LVL_RANGE: assert property (arb.found && arb.winIdx != 4'h0
        |-> arb.winLvl <= 3'h3)
        else $error("non power-fail level above 3");
    AST_PF_LEVEL4: assert property (taken && winIdx_q == 4'h0
        |-> intLevel == 3'h4 && vectorAddr == 8'h33)
        else $error("power-fail not taken at level 4");
    AST_VEC_EXT0: assert property (taken && winIdx_q == 4'h1
        |-> vectorAddr == 8'h03)
        else $error("wrong vector for external 0");
    AST_VEC_WD: assert property (intReq && winIdx_q == 4'hc
        |-> vectorAddr == 8'h63)
        else $error("wrong vector for watchdog");
    AST_FLAG_ANY_EN: assert property (tmr1Ovf |=> tmrCtl_q[7])
        else $error("timer 1 flag not set on overflow");
    AST_EDGE_CLR: assert property (taken && winIdx_q == 4'h1 && edge0
        && !ext0Fall |=> !tmrCtl_q[1])
        else $error("edge flag not cleared on vectoring");
    AST_LEVEL_PIN: assert property (!edge0 ##1 !edge0
        |-> tmrCtl_q[1] == !$past(ext0PinN))
        else $error("level flag does not follow pin");
    AST_TF_CLR: assert property (taken && winIdx_q == 4'h2
        && !tmr0Ovf |=> !tmrCtl_q[5])
        else $error("timer 0 flag not cleared on vectoring");
    AST_T2_SHARED: assert property (tmr2Ext && !tmr2Ovf && !regWr
        && intEn_q[5] && globalEn |=> arb.pending[6] && tmr2Ctl_q[6]
        && $stable(tmr2Ctl_q[7]))
        else $error("timer 2 external flag not requesting");
    AST_EXT_EN: assert property (!extEn_q[4] |-> !arb.pending[12])
        else $error("watchdog requests while disabled");
    AST_GLOBAL: assert property (!globalEn && !arb.pending[0]
        |=> !intReq)
        else $error("request taken with global enable off");
    AST_PF_IGNORES_EA: assert property (!globalEn && wdCtl_q[4]
        && wdCtl_q[5] |-> arb.pending[0])
        else $error("power-fail blocked by global enable");
    AST_LVL_PAIR: assert property (arb.pending[3] && prioHigh_q[2]
        && !prioLow_q[2] |-> arb.level[3] == 3'h2)
        else $error("level pair formed wrongly");
    AST_NO_PREEMPT: assert property (active && curLvl == 3'h3
        && !arb.pending[0] |=> !intReq)
        else $error("equal level preempted service");

    COV_PF_TAKEN: cover property (taken && winIdx_q == 4'h0);
    COV_NESTED: cover property (taken && active);
    COV_RETURN: cover property (taken ##[1:20] retiDone);
endmodule // fic_irq_ctrl

// ==== design/fic_level_stack.sv ====
// Tracks the levels in service for nesting and return
`timescale 1ns/1ps
module fic_level_stack (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic push,
    input wire fic_pkg::fic_lvl_t pushLvl,
    input wire logic pop,
    output logic [4:0] inService,
    output fic_pkg::fic_lvl_t curLvl,
    output logic active
);
    logic [4:0] inService_q;
    logic [4:0] popMask;
    logic [4:0] pushMask;

    function automatic fic_pkg::fic_lvl_t topBit(input logic [4:0] v);
        fic_pkg::fic_lvl_t r;
        r = 3'h0;
        for (int i = 0; i < 5; i++)
            if (v[i])
                r = 3'(i);
        return r;
    endfunction

    assign curLvl = topBit(inService_q);
    assign active = |inService_q;
    assign inService = inService_q;
    assign popMask = (pop && active) ? (5'h01 << curLvl) : 5'h00;
    assign pushMask = push ? (5'h01 << pushLvl) : 5'h00;

    // Return drops the newest level before a new entry lands
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            inService_q <= 5'h00;
        else
            inService_q <= (inService_q & ~popMask) | pushMask;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_POP_LOWERS: assert property (pop && !push && active
        |=> !active || curLvl < $past(curLvl))
        else $error("return did not lower the level in service");
endmodule // fic_level_stack

// ==== design/fic_pkg.sv ====
// Shared constants and types of the five-level interrupt controller
package fic_pkg;
    localparam int NumSrc = 13;
    typedef logic [3:0] fic_idx_t;
    typedef logic [2:0] fic_lvl_t;
    typedef logic [7:0] fic_byte_t;

    // Source order, lowest number wins a tie
    localparam fic_idx_t SrcPf = 4'h0;
    localparam fic_idx_t SrcExt0 = 4'h1;
    localparam fic_idx_t SrcTmr0 = 4'h2;
    localparam fic_idx_t SrcExt1 = 4'h3;
    localparam fic_idx_t SrcTmr1 = 4'h4;
    localparam fic_idx_t SrcSer0 = 4'h5;
    localparam fic_idx_t SrcTmr2 = 4'h6;
    localparam fic_idx_t SrcSer1 = 4'h7;
    localparam fic_idx_t SrcExt2 = 4'h8;
    localparam fic_idx_t SrcWd = 4'hc;
    localparam fic_lvl_t LvlPf = 3'h4;

    // Register offsets
    localparam fic_byte_t RegTmrCtl = 8'h88;
    localparam fic_byte_t RegExtFlags = 8'h91;
    localparam fic_byte_t RegSer0 = 8'h98;
    localparam fic_byte_t RegSer1 = 8'hc0;
    localparam fic_byte_t RegIntEn = 8'ha8;
    localparam fic_byte_t RegPrioLow = 8'hb8;
    localparam fic_byte_t RegPrioHigh = 8'hb9;
    localparam fic_byte_t RegTmr2Ctl = 8'hc8;
    localparam fic_byte_t RegWdPwr = 8'hd8;
    localparam fic_byte_t RegExtEn = 8'he8;
    localparam fic_byte_t RegExtPrioLow = 8'hf8;
    localparam fic_byte_t RegExtPrioHigh = 8'hf9;
    localparam fic_byte_t RegEvtStatus = 8'hfa;
    localparam fic_byte_t RegEvtMask = 8'hfb;
    localparam fic_byte_t RegInService = 8'hfc;
    localparam fic_byte_t RstVal = 8'h00;

    // Field positions
    localparam int TcEdge0 = 0;
    localparam int TcFlag0 = 1;
    localparam int TcEdge1 = 2;
    localparam int TcFlag1 = 3;
    localparam int TcTf0 = 5;
    localparam int TcTf1 = 7;
    localparam int ExfExt2 = 4;
    localparam int SerRx = 0;
    localparam int SerTx = 1;
    localparam int T2Exf = 6;
    localparam int T2Tf = 7;
    localparam int WdWdif = 3;
    localparam int WdPfi = 4;
    localparam int WdEpfi = 5;
    localparam int IeGlobal = 7;
    localparam int EieWd = 4;
    localparam int EvTake = 0;
    localparam int EvNest = 1;
    localparam int EvRet = 2;
    localparam int EvRetErr = 3;

    localparam fic_byte_t VecTable [NumSrc] = '{8'h33, 8'h03, 8'h0b,
        8'h13, 8'h1b, 8'h23, 8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53,
        8'h5b, 8'h63};

    function automatic fic_byte_t vecOf(input fic_idx_t idx);
        return (idx < 4'hd) ? VecTable[idx] : 8'h00;
    endfunction
endpackage

// ==== dv/fic_core_model.sv ====
// Core model: takes vectors promptly or slowly, reports each take
`timescale 1ns/1ps
module fic_core_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic intReq,
    input wire logic [7:0] vectorAddr,
    input wire fic_pkg::fic_lvl_t intLevel,
    output logic vecAck,
    output logic taken,
    output logic [7:0] takenVec,
    output fic_pkg::fic_lvl_t takenLvl
);
    logic [1:0] waitQ;
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset || vecAck || !intReq)
        begin
            vecAck <= 1'b0;
            waitQ <= 2'h0;
        end
        else if (!slow || waitQ == 2'h3)
            vecAck <= 1'b1;
        else
            waitQ <= waitQ + 2'h1;
    end
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            taken <= 1'b0;
        else
            taken <= vecAck && intReq;
        if (!reset && vecAck && intReq)
        begin
            takenVec <= vectorAddr;
            takenLvl <= intLevel;
        end
    end
endmodule // fic_core_model

// ==== dv/tb.sv ====
// Self-checking bench of the five-level interrupt controller
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [13:0] evt = 14'h0;
    logic ext0N = 1'b1;
    logic ext1N = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic retiDone = 1'b0;
    logic slow = 1'b0;
    logic [7:0] regRdData, vectorAddr, takenVec;
    fic_pkg::fic_lvl_t intLevel, takenLvl;
    logic vecAck, intReq, irqOut, taken;
    int failures = 0;
    int n_checks = 0;
    logic [7:0] vecExp [13] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
        8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
    logic [7:0] clrA [13] = '{8'hd8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h98,
        8'hc8, 8'hc0, 8'h91, 8'h91, 8'h91, 8'h91, 8'hd8};
    logic [7:0] clrD [13] = '{8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'he0, 8'hc0, 8'h80, 8'h00, 8'h20};
    always #20 ref_clk = ~ref_clk;
    fic_irq_ctrl uut (.ref_clk(ref_clk), .reset(reset), .ext0PinN(ext0N),
        .ext1PinN(ext1N), .pfDetect(evt[0]), .tmr0Ovf(evt[1]),
        .tmr1Ovf(evt[2]), .tmr2Ovf(evt[3]), .tmr2Ext(evt[4]),
        .ser0Rx(evt[5]), .ser0Tx(evt[6]), .ser1Rx(evt[7]), .ser1Tx(evt[8]),
        .extHiEvt(evt[12:9]), .wdTimeout(evt[13]), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .vecAck(vecAck), .retiDone(retiDone),
        .intReq(intReq), .vectorAddr(vectorAddr), .intLevel(intLevel),
        .irqOut(irqOut));
    fic_core_model core (.ref_clk(ref_clk), .reset(reset), .slow(slow),
        .intReq(intReq), .vectorAddr(vectorAddr), .intLevel(intLevel),
        .vecAck(vecAck), .taken(taken), .takenVec(takenVec),
        .takenLvl(takenLvl));
    task automatic conclude();
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", nm, e, g);
            failures++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        chk($sformatf("reg %h", a), e, regRdData);
    endtask
    task automatic fire(input logic [13:0] m);
        @(posedge ref_clk);
        evt <= m;
        @(posedge ref_clk);
        evt <= 14'h0;
    endtask
    task automatic reti();
        @(posedge ref_clk);
        retiDone <= 1'b1;
        @(posedge ref_clk);
        retiDone <= 1'b0;
    endtask
    task automatic take(input logic [7:0] v, input logic [7:0] l);
        int k;
        k = 0;
        do
        begin
            @(negedge ref_clk);
            k++;
        end
        while (taken !== 1'b1 && k < 200);
        chk("take", 8'h01, {7'h0, taken});
        chk("vector", v, takenVec);
        chk("level", l, {5'h0, takenLvl});
    endtask
    task automatic t_regs();
        rd(8'h91, 8'h00);
        rd(8'hd8, 8'h00);
        rd(8'he8, 8'h00);
        wr(8'he8, 8'hff);
        rd(8'he8, 8'hff);
        rd(8'h00, 8'h00);
        @(posedge ref_clk);
        ext0N <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(8'h88, 8'h02);
        @(posedge ref_clk);
        ext0N <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(8'h88, 8'h00);
    endtask
    task automatic t_order();
        wr(8'ha8, 8'hff);
        wr(8'he8, 8'h1f);
        wr(8'hd8, 8'h20);
        wr(8'h88, 8'h05);
        ext0N <= 1'b0;
        ext1N <= 1'b0;
        fire(14'h3fef);
        for (int i = 0; i < 13; i++)
        begin
            take(vecExp[i], (i == 0) ? 8'h04 : 8'h00);
            wr(clrA[i], clrD[i]);
            @(negedge ref_clk);
            chk("hold", 8'h00, {7'h0, intReq});
            reti();
        end
        ext0N <= 1'b1;
        ext1N <= 1'b1;
    endtask
    task automatic t_prio();
        slow <= 1'b1;
        wr(8'hb8, 8'h0a);
        wr(8'hb9, 8'h18);
        fire(14'h0022);
        take(8'h23, 8'h02);
        wr(8'h98, 8'h00);
        fire(14'h0004);
        take(8'h1b, 8'h03);
        rd(8'hfc, 8'h0c);
        reti();
        repeat (4) @(negedge ref_clk);
        chk("wait", 8'h00, {7'h0, intReq});
        reti();
        take(8'h0b, 8'h01);
        reti();
        slow <= 1'b0;
    endtask
    task automatic t_gate();
        wr(8'ha8, 8'h22);
        fire(14'h0012);
        repeat (4) @(negedge ref_clk);
        chk("gated", 8'h00, {7'h0, intReq});
        rd(8'h88, 8'h25);
        rd(8'hc8, 8'h40);
        fire(14'h0001);
        take(8'h33, 8'h04);
        wr(8'hd8, 8'h20);
        reti();
        wr(8'ha8, 8'ha2);
        fire(14'h0010);
        take(8'h0b, 8'h01);
        reti();
        take(8'h2b, 8'h00);
        wr(8'hc8, 8'h00);
        reti();
    endtask
    task automatic t_irq();
        @(negedge ref_clk);
        chk("irq", 8'h00, {7'h0, irqOut});
        wr(8'hfb, 8'h01);
        repeat (2) @(negedge ref_clk);
        chk("irq", 8'h01, {7'h0, irqOut});
        rd(8'hfa, 8'h07);
        repeat (2) @(negedge ref_clk);
        chk("irq", 8'h00, {7'h0, irqOut});
        reti();
        rd(8'hfa, 8'h08);
        rd(8'hfa, 8'h00);
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_order();
        t_prio();
        t_gate();
        t_irq();
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude();
    end
endmodule // tb
